/* fault_deglitch.sv */
// Purpose: Symmetric deglitch of one fault level
// Assumes: level_in already synchronised to ref_clk
// Notes: Output follows input after COUNT steady cycles
`timescale 1ns/10ps
module fault_deglitch import usb_fault_pkg::*; #(
  parameter int COUNT = DEGLITCH_CYCLES
) (
  // Clocking
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // Level
  input wire logic level_in,
  output logic level_out
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] count;

  if (COUNT < 1) begin : g_bad_count
    $error("fault_deglitch: COUNT must be at least 1");
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count <= '0;
      level_out <= 1'b0;
    end else if (ce) begin
      if (level_in == level_out) begin
        count <= '0;
      end else if (count == CW'(COUNT - 1)) begin
        count <= '0;
        level_out <= level_in;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  sequence s_settled;
    ce && level_in != level_out && count == CW'(COUNT - 1);
  endsequence
  sequence s_steady;
    ce && level_in == level_out;
  endsequence
  a_deglitch_flip: assert property (@(posedge ref_clk) disable iff (srst)
    s_settled |=> level_out == $past(level_in)) else $error("deglitch did not flip at count end");
  a_deglitch_hold: assert property (@(posedge ref_clk) disable iff (srst)
    s_steady |=> $stable(level_out) && count == '0) else $error("deglitch moved on steady input");
endmodule

/* hiccup_fault_timer.sv */
// Purpose: Hiccup detection and fault window timing
// Assumes: cycle_tick is a one-cycle pulse per switching cycle
// Notes: Any cycle without a short restarts the run count
`timescale 1ns/10ps
module hiccup_fault_timer import usb_fault_pkg::*; #(
  parameter int CYCLES = HICCUP_CYCLE_COUNT,
  parameter int HOLD = HICCUP_HOLD_CYCLES
) (
  // Clocking
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // Short detection
  input wire logic cycle_tick,
  input wire logic short_seen,
  output logic window
);
  localparam int SW = $clog2(CYCLES + 1);
  localparam int HW = $clog2(HOLD + 1);
  hiccup_state_t state;
  logic [SW-1:0] run_count;
  logic [HW-1:0] hold_count;

  if (CYCLES < 1 || HOLD < 1) begin : g_bad_count
    $error("hiccup_fault_timer: counts must be at least 1");
  end

  assign window = (state == HC_HOLD);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= HC_RUN;
      run_count <= '0;
      hold_count <= '0;
    end else if (ce) begin
      unique case (state)
        HC_RUN: begin
          if (cycle_tick && !short_seen) begin
            run_count <= '0;
          end else if (cycle_tick && run_count == SW'(CYCLES - 1)) begin
            run_count <= '0;
            hold_count <= '0;
            state <= HC_HOLD;
          end else if (cycle_tick) begin
            run_count <= run_count + 1'b1;
          end
        end
        HC_HOLD: begin
          if (hold_count == HW'(HOLD - 1)) begin
            state <= HC_RUN;
          end else begin
            hold_count <= hold_count + 1'b1;
          end
        end
      endcase
    end
  end

  a_hiccup_entry: assert property (@(posedge ref_clk) disable iff (srst)
    ce && state == HC_RUN && cycle_tick && short_seen && run_count == SW'(CYCLES - 1) |=> window)
    else $error("hiccup window not opened at cycle count");
  a_hiccup_exit: assert property (@(posedge ref_clk) disable iff (srst)
    ce && window && hold_count == HW'(HOLD - 1) |=> !window) else $error("hiccup window overran hold");
endmodule

/* host_fault_monitor.sv */
// Purpose: Host side of the fault and thermal warning pins
// Assumes: Host supplies the pull-up on the fault wire
// Notes: Wire is high whenever the device lets go
`timescale 1ns/10ps
module host_fault_monitor (
  // Device pins
  input wire logic fault_pin_out,
  input wire logic fault_pin_oe_n,
  input wire logic thermal_warning_flag,
  // Host view
  output logic fault_seen_n,
  output logic warn_seen
);
  // Pull-up wins when the drain is off
  assign fault_seen_n = fault_pin_oe_n ? 1'b1 : fault_pin_out;
  assign warn_seen = thermal_warning_flag;
endmodule

/* usb_fault_pkg.sv */
// Purpose: Shared constants for the port fault response block
// Assumes: 250 MHz ref_clk, AXI4-Lite register access
// Notes: Event and status registers share one bit layout
package usb_fault_pkg;
  localparam int CLK_KHZ = 250000;
  localparam int DEGLITCH_MS = 8;
  localparam int DEGLITCH_CYCLES = DEGLITCH_MS * CLK_KHZ;
  localparam int HICCUP_HOLD_MS = 118;
  localparam int HICCUP_HOLD_CYCLES = HICCUP_HOLD_MS * CLK_KHZ;
  localparam int HICCUP_CYCLE_COUNT = 128;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
  localparam int CTRL_LIMIT_GATE = 0;
  localparam int CTRL_ADV_3A = 1;
  localparam int CTRL_VCONN_EN = 2;
  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RESET = 3'h6;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int EV_BUS_OV = 0;
  localparam int EV_DLINE_OV = 1;
  localparam int EV_CC_OV = 2;
  localparam int EV_VCONN_OC = 3;
  localparam int EV_HICCUP = 4;
  localparam int EV_WARN = 5;
  localparam int EV_SHUTDOWN = 6;
  localparam int EV_FAULT = 7;
  localparam int NUM_EV = 8;
  localparam int NUM_DG = 4;
  localparam int IN_BUS_OV = 0;
  localparam int IN_DP_OV = 1;
  localparam int IN_DM_OV = 2;
  localparam int IN_CC1_OV = 3;
  localparam int IN_CC2_OV = 4;
  localparam int IN_VCONN_OC = 5;
  localparam int IN_OUT_OC = 6;
  localparam int IN_SHORT = 7;
  localparam int IN_TICK = 8;
  localparam int IN_WARN = 9;
  localparam int IN_SD = 10;
  localparam int NUM_IN = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {HC_RUN = 1'b0, HC_HOLD = 1'b1} hiccup_state_t;
endpackage

/* usb_port_fault_response.sv */
// Purpose: Fault and warning response of a USB charging port
// Assumes: Comparator outcomes arrive asynchronously on pins
// Notes: Registers over AXI4-Lite, one level interrupt
// Functional notes
// - Overcurrent is limited by gate or buck loop, never flagged as fault
// - Hiccup after cycle count raises fault for the hold time
// - Bus overvoltage: discharge on, gate off at once, fault deglitched 8 ms
// - Data line overvoltage opens data switches at once, fault deglitched 8 ms
// - CC overvoltage disconnects CC lines at once, fault deglitched 8 ms
// - VCONN overcurrent raises deglitched fault while it lasts, VCONN stays on
// - Thermal warning level sets warning flag with no deglitch
// - Thermal warning drops a 3 A advertisement to 1.5 A
// - Thermal warning alone never raises fault; other faults still do
// - Shutdown level stops buck, opens data switches, pulls gate and bus low
// - Warning flag stays set during thermal shutdown
// - Fault pin is active-low open drain; host supplies the pull-up
// - Bus overvoltage clearing restores gate drive and releases fault
// - Data overvoltage clearing removes discharge and recloses switches
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module usb_port_fault_response import usb_fault_pkg::*; #(
  parameter int DEGLITCH = DEGLITCH_CYCLES,
  parameter int HICCUP_HOLD = HICCUP_HOLD_CYCLES,
  parameter int HICCUP_CYCLES = HICCUP_CYCLE_COUNT
) (
  // Clocking
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // Comparator pins
  input wire logic bus_ov_in,
  input wire logic host_data_plus_line_ov,
  input wire logic host_data_minus_line_ov,
  input wire logic cc1_ov,
  input wire logic cc2_ov,
  input wire logic vconn_oc,
  input wire logic out_oc,
  input wire logic buck_short,
  input wire logic buck_cycle,
  input wire logic thermistor_sense_input_warn,
  input wire logic thermistor_sense_input_shutdown,
  // Power path actions
  output logic load_switch_gate_drive,
  output logic gate_current_limit,
  output logic buck_current_limit,
  output logic buck_enable,
  output logic bus_discharge,
  output logic data_switch_enable,
  output logic data_line_discharge,
  output logic cc_connect,
  output logic cc_discharge,
  output logic vconn_enable,
  output logic advertise_3a,
  // Host facing flags
  output logic fault_pin_out,
  output logic fault_pin_oe_n,
  output logic thermal_warning_flag,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (DEGLITCH < 1 || HICCUP_HOLD < 1 || HICCUP_CYCLES < 1) begin : g_bad_param
    $error("usb_port_fault_response: counts must be at least 1");
  end

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = addr == ADDR_CTRL || addr == ADDR_STATUS ||
                addr == ADDR_INT_STATUS || addr == ADDR_INT_MASK;
  endfunction

  logic [NUM_IN-1:0] raw_pins;
  logic [NUM_IN-1:0] sync_a;
  logic [NUM_IN-1:0] sync_b;
  logic tick_d;
  logic tick_pulse;
  logic bus_ov_s, dline_ov_s, cc_ov_s, vconn_oc_s, oc_s, warn_s, sd_s;
  logic [NUM_DG-1:0] dg_raw;
  logic [NUM_DG-1:0] dg_out;
  logic hiccup_window;
  logic fault_any;
  logic [NUM_EV-1:0] status_now;
  logic [NUM_EV-1:0] status_prev;
  logic [NUM_EV-1:0] events;
  logic [CTRL_W-1:0] ctrl;
  logic [NUM_EV-1:0] int_status;
  logic [NUM_EV-1:0] int_mask;
  logic aw_have, w_have;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] next_rdata;

  assign raw_pins = {thermistor_sense_input_shutdown, thermistor_sense_input_warn, buck_cycle,
                     buck_short, out_oc, vconn_oc, cc2_ov, cc1_ov, host_data_minus_line_ov,
                     host_data_plus_line_ov, bus_ov_in};

  // Two stages before any logic looks at a pin
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_a <= '0;
      sync_b <= '0;
      tick_d <= 1'b0;
    end else if (ce) begin
      sync_a <= raw_pins;
      sync_b <= sync_a;
      tick_d <= sync_b[IN_TICK];
    end
  end

  assign tick_pulse = sync_b[IN_TICK] && !tick_d;
  assign bus_ov_s = sync_b[IN_BUS_OV];
  assign dline_ov_s = sync_b[IN_DP_OV] || sync_b[IN_DM_OV];
  assign cc_ov_s = sync_b[IN_CC1_OV] || sync_b[IN_CC2_OV];
  assign vconn_oc_s = sync_b[IN_VCONN_OC];
  assign oc_s = sync_b[IN_OUT_OC];
  assign warn_s = sync_b[IN_WARN];
  assign sd_s = sync_b[IN_SD];

  // Sources that reach the fault pin only after deglitch
  assign dg_raw[EV_BUS_OV] = bus_ov_s;
  assign dg_raw[EV_DLINE_OV] = dline_ov_s;
  assign dg_raw[EV_CC_OV] = cc_ov_s;
  assign dg_raw[EV_VCONN_OC] = vconn_oc_s;

  for (genvar i = 0; i < NUM_DG; i++) begin : g_deglitch
    fault_deglitch #(.COUNT(DEGLITCH)) u_dg (
      .ref_clk(ref_clk),
      .srst(srst),
      .ce(ce),
      .level_in(dg_raw[i]),
      .level_out(dg_out[i])
    );
  end

  hiccup_fault_timer #(.CYCLES(HICCUP_CYCLES), .HOLD(HICCUP_HOLD)) u_hiccup (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .cycle_tick(tick_pulse),
    .short_seen(sync_b[IN_SHORT]),
    .window(hiccup_window)
  );

  // Overcurrent itself is absent here: minor overload never flags
  assign fault_any = |dg_out || hiccup_window;

  // Immediate actions, no deglitch on any of them
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      load_switch_gate_drive <= 1'b0;
      bus_discharge <= 1'b0;
      buck_enable <= 1'b0;
    end else if (ce) begin
      load_switch_gate_drive <= !bus_ov_s && !sd_s;
      bus_discharge <= bus_ov_s || sd_s;
      buck_enable <= !sd_s && !hiccup_window;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_switch_enable <= 1'b0;
      data_line_discharge <= 1'b0;
      cc_connect <= 1'b0;
      cc_discharge <= 1'b0;
    end else if (ce) begin
      data_switch_enable <= !dline_ov_s && !sd_s;
      data_line_discharge <= dline_ov_s;
      cc_connect <= !cc_ov_s;
      cc_discharge <= cc_ov_s;
    end
  end

  // Limiting path picked by software; the other path stays idle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gate_current_limit <= 1'b0;
      buck_current_limit <= 1'b0;
    end else if (ce) begin
      gate_current_limit <= oc_s && ctrl[CTRL_LIMIT_GATE];
      buck_current_limit <= oc_s && !ctrl[CTRL_LIMIT_GATE];
    end
  end

  // VCONN follows software only; its overload never cuts it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vconn_enable <= 1'b0;
      advertise_3a <= 1'b0;
      thermal_warning_flag <= 1'b0;
    end else if (ce) begin
      vconn_enable <= ctrl[CTRL_VCONN_EN];
      advertise_3a <= ctrl[CTRL_ADV_3A] && !warn_s && !sd_s;
      thermal_warning_flag <= warn_s || sd_s;
    end
  end

  // Pin is only ever pulled low; the pull-up is outside
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_pin_out <= 1'b0;
      fault_pin_oe_n <= 1'b1;
    end else if (ce) begin
      fault_pin_out <= 1'b0;
      fault_pin_oe_n <= !fault_any;
    end
  end

  assign status_now = {fault_any, sd_s, warn_s, hiccup_window, dg_out};
  assign events = status_now & ~status_prev;

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_prev <= '0;
      int_status <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      status_prev <= status_now;
      if (do_write && aw_addr == ADDR_INT_STATUS && w_strb[0]) begin
        int_status <= (int_status & ~w_data[NUM_EV-1:0]) | events;
      end else begin
        int_status <= int_status | events;
      end
      irq <= |(int_status & int_mask);
    end
  end

  // Write channel: address and data taken in either order
  assign do_write = aw_have && w_have && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_have <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have <= 1'b0;
      end
      s_axi_awready <= !aw_have && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      w_have <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_have <= 1'b0;
      end
      s_axi_wready <= !w_have && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // All fields sit in byte lane 0
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl <= CTRL_RESET;
      int_mask <= MASK_RESET;
    end else if (ce && do_write && w_strb[0]) begin
      if (aw_addr == ADDR_CTRL) begin
        ctrl <= w_data[CTRL_W-1:0];
      end
      if (aw_addr == ADDR_INT_MASK) begin
        int_mask <= w_data[NUM_EV-1:0];
      end
    end
  end

  always_comb begin
    next_rdata = '0;
    unique case (s_axi_araddr)
      ADDR_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
      ADDR_STATUS: next_rdata[NUM_EV-1:0] = status_now;
      ADDR_INT_STATUS: next_rdata[NUM_EV-1:0] = int_status;
      ADDR_INT_MASK: next_rdata[NUM_EV-1:0] = int_mask;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_gate_bus_ov: assert property (@(posedge ref_clk) disable iff (srst)
    ce && bus_ov_s |=> !load_switch_gate_drive && bus_discharge) else $error("gate not dropped on bus ov");
  a_gate_restore: assert property (@(posedge ref_clk) disable iff (srst)
    ce && !bus_ov_s && !sd_s |=> load_switch_gate_drive) else $error("gate not restored");
  a_data_open: assert property (@(posedge ref_clk) disable iff (srst)
    ce && dline_ov_s |=> !data_switch_enable && data_line_discharge) else $error("data switch not opened");
  a_cc_disconnect: assert property (@(posedge ref_clk) disable iff (srst)
    ce && cc_ov_s |=> !cc_connect && cc_discharge) else $error("cc not disconnected");
  a_vconn_kept: assert property (@(posedge ref_clk) disable iff (srst)
    ce && vconn_oc_s |=> vconn_enable == $past(ctrl[CTRL_VCONN_EN])) else $error("vconn cut on overload");
  a_warn_flag: assert property (@(posedge ref_clk) disable iff (srst)
    ce && (warn_s || sd_s) |=> thermal_warning_flag) else $error("warning flag late");
  a_advert_drop: assert property (@(posedge ref_clk) disable iff (srst)
    ce && warn_s |=> !advertise_3a) else $error("3 A still advertised in warning");
  a_shutdown_all: assert property (@(posedge ref_clk) disable iff (srst)
    ce && sd_s |=> !buck_enable && !data_switch_enable && !load_switch_gate_drive && bus_discharge)
    else $error("shutdown actions missing");
  a_fault_or: assert property (@(posedge ref_clk) disable iff (srst)
    ce |=> fault_pin_oe_n == !$past(fault_any)) else $error("fault pin not the fault OR");
  a_limit_path: assert property (@(posedge ref_clk) disable iff (srst)
    ce && oc_s |=> gate_current_limit != buck_current_limit) else $error("no single limit path");
endmodule

/* usb_port_fault_response_test.sv */
// Purpose: Self-checking bench for the port fault response block
// Assumes: Short deglitch and hiccup counts set by parameter
// Notes: Registers reached over AXI4-Lite tasks
`timescale 1ns/10ps
module usb_port_fault_response_test import usb_fault_pkg::*; ;
  localparam int DG = 8;
  localparam int HOLD = 20;
  localparam int NCYC = 4;
  // Actions: gate, bus dis, data sw, data dis, cc, cc dis, vconn
  localparam logic [6:0] ACT [6] = '{7'h35, 7'h4d, 7'h4d, 7'h53, 7'h53, 7'h55};
  logic ref_clk, srst, ce, buck_short, buck_cycle, warn, sd;
  logic [6:0] pin;
  logic load_switch_gate_drive, gate_current_limit, buck_current_limit, buck_enable, bus_discharge;
  logic data_switch_enable, data_line_discharge, cc_connect, cc_discharge, vconn_enable, advertise_3a;
  logic fault_pin_out, fault_pin_oe_n, thermal_warning_flag, irq, fault_seen_n, warn_seen;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int num_errors = 0;
  int num_checks = 0;
  wire [6:0] act = {load_switch_gate_drive, bus_discharge, data_switch_enable, data_line_discharge,
                    cc_connect, cc_discharge, vconn_enable};

  usb_port_fault_response #(.DEGLITCH(DG), .HICCUP_HOLD(HOLD), .HICCUP_CYCLES(NCYC))
    i_usb_port_fault_response (
    .ref_clk, .srst, .ce, .bus_ov_in(pin[0]), .host_data_plus_line_ov(pin[1]),
    .host_data_minus_line_ov(pin[2]), .cc1_ov(pin[3]), .cc2_ov(pin[4]), .vconn_oc(pin[5]), .out_oc(pin[6]),
    .buck_short, .buck_cycle, .thermistor_sense_input_warn(warn), .thermistor_sense_input_shutdown(sd),
    .load_switch_gate_drive, .gate_current_limit, .buck_current_limit, .buck_enable, .bus_discharge,
    .data_switch_enable, .data_line_discharge, .cc_connect, .cc_discharge, .vconn_enable, .advertise_3a,
    .fault_pin_out, .fault_pin_oe_n, .thermal_warning_flag, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  host_fault_monitor i_host_fault_monitor (
    .fault_pin_out, .fault_pin_oe_n, .thermal_warning_flag, .fault_seen_n, .warn_seen);

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo(input int t);
    if (t >= 50) begin
      num_errors++;
      results();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 50);
    s_axi_bready <= 1'b0;
    tmo(t);
    chk(s_axi_bresp, er);
    @(posedge ref_clk);
  endtask

  task automatic rdr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 50);
    s_axi_rready <= 1'b0;
    tmo(t);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    @(posedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    srst <= 1'b1;
    ce <= 1'b1;
    pin <= 7'h00;
    buck_short <= 1'b0;
    buck_cycle <= 1'b0;
    warn <= 1'b0;
    sd <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    cyc(4);
    srst <= 1'b0;
    cyc(4);
    rdr(ADDR_CTRL, {29'h0, CTRL_RESET}, RESP_OKAY);
    rdr(ADDR_INT_MASK, 32'h0, RESP_OKAY);
    rdr(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    wr(ADDR_INT_MASK, 32'h1, RESP_OKAY);
    // Lane 0 not strobed: answered, but nothing changes
    s_axi_wstrb <= 4'he;
    wr(ADDR_INT_MASK, 32'hff, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rdr(ADDR_INT_MASK, 32'h1, RESP_OKAY);
    done("registers");
    // Each source alone: actions at once, fault only after the deglitch
    for (int i = 0; i < 6; i++) begin
      pin[i] <= 1'b1;
      cyc(4);
      chk(act, ACT[i]);
      chk(fault_seen_n, 1'b1);
      cyc(10);
      chk(fault_seen_n, 1'b0);
      pin[i] <= 1'b0;
      cyc(4);
      chk(act, 7'h55);
      chk(fault_seen_n, 1'b0);
      cyc(10);
      chk(fault_seen_n, 1'b1);
    end
    chk(irq, 1'b1);
    rdr(ADDR_INT_STATUS, 32'h8f, RESP_OKAY);
    wr(ADDR_INT_STATUS, 32'h1, RESP_OKAY);
    cyc(2);
    chk(irq, 1'b0);
    wr(ADDR_INT_STATUS, 32'hff, RESP_OKAY);
    done("faults");
    // Enable low freezes the pin path and every output
    ce <= 1'b0;
    pin[0] <= 1'b1;
    cyc(6);
    chk(act, 7'h55);
    ce <= 1'b1;
    cyc(4);
    chk(act, 7'h35);
    // Gone before the deglitch ends: no fault
    pin[0] <= 1'b0;
    cyc(20);
    chk({act, fault_seen_n}, 8'hab);
    done("enable");
    pin[6] <= 1'b1;
    cyc(4);
    chk({gate_current_limit, buck_current_limit}, 2'h1);
    wr(ADDR_CTRL, 32'h7, RESP_OKAY);
    cyc(2);
    chk({gate_current_limit, buck_current_limit}, 2'h2);
    cyc(12);
    chk(fault_seen_n, 1'b1);
    pin[6] <= 1'b0;
    wr(ADDR_CTRL, 32'h6, RESP_OKAY);
    done("overcurrent");
    buck_short <= 1'b1;
    repeat (NCYC) begin
      buck_cycle <= 1'b1;
      cyc(4);
      buck_cycle <= 1'b0;
      cyc(4);
    end
    chk({buck_enable, fault_seen_n}, 2'h0);
    buck_short <= 1'b0;
    cyc(HOLD + 5);
    chk({buck_enable, fault_seen_n}, 2'h3);
    done("hiccup");
    warn <= 1'b1;
    cyc(4);
    chk({warn_seen, advertise_3a}, 2'h2);
    cyc(14);
    chk(fault_seen_n, 1'b1);
    sd <= 1'b1;
    cyc(4);
    chk({buck_enable, data_switch_enable, load_switch_gate_drive, bus_discharge, warn_seen}, 5'h3);
    rdr(ADDR_STATUS, 32'h60, RESP_OKAY);
    // Another fault still reaches the pin while hot
    pin[5] <= 1'b1;
    cyc(14);
    chk(fault_seen_n, 1'b0);
    sd <= 1'b0;
    warn <= 1'b0;
    pin[5] <= 1'b0;
    cyc(28);
    chk({advertise_3a, fault_seen_n}, 2'h3);
    done("thermal");
    results();
  end
endmodule
